// ===== ccr_params.svh
// Offsets, field positions and reset values of the clock synth registers.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define CCR_IX_STBY     10'h250
`define CCR_IX_SYN_EN   10'h2a0
`define CCR_IX_NLO      10'h2a1
`define CCR_IX_NHI      10'h2a2
`define CCR_IX_CAL_RST  10'h2a5
`define CCR_IX_BIAS     10'h2aa
`define CCR_IX_VCO_CAL  10'h2ab
`define CCR_IX_PUMP     10'h2ac
`define CCR_IX_PCAL     10'h2ad
`define CCR_IX_VAR      10'h2b7
`define CCR_IX_RDIV     10'h2bb
`define CCR_IX_CONV_ST  10'h2bc
`define CCR_IX_LINK_ST  10'h2dc
`define CCR_IX_SHUF     10'h340
`define CCR_IX_TH_LO    10'h342
`define CCR_IX_TH_HI    10'h343
`define CCR_IX_IRQ_EN   10'h380
`define CCR_IX_IRQ_STS  10'h381
`define CCR_IX_IRQ_CLR  10'h382

// Reset values of the writable registers.
`define CCR_RST_STBY    8'hff
`define CCR_RST_SYN_EN  8'h00
`define CCR_RST_NLO     8'h80
`define CCR_RST_NHI     8'h00
`define CCR_RST_CAL_RST 8'h00
`define CCR_RST_BIAS    8'h37
`define CCR_RST_VCO_CAL 8'hc0
`define CCR_RST_PUMP    8'h19
`define CCR_RST_PCAL    8'h00
`define CCR_RST_VAR     8'hd0
`define CCR_RST_RDIV    8'hb9
`define CCR_RST_SHUF    8'h03

// Read-only contents: status upper nibble and shuffle thresholds.
`define CCR_ST_TOP      4'h8
`define CCR_TH_LO_RST   8'hf5
`define CCR_TH_HI_RST   8'hff

// Field positions.
`define CCR_RDIV_HI     7
`define CCR_RDIV_LO     6
`define CCR_SYSREF_BIT  3
`define CCR_CLKIN_BIT   2
`define CCR_LOCK_BIT    3
`define CCR_BUSY_BIT    1
`define CCR_DONE_BIT    0
`define CCR_SHUF_EN_BIT 0

// Sizes of the register array and of the event set.
`define CCR_NRW         12
`define CCR_NEVT        4

`endif

// ===== ccr_pkg.sv
// Types shared by the clock synth register block and its helpers.
package ccr_pkg;

  // Shuffle rate chosen from the current sample, one-hot coded.
  typedef enum logic [4:0] {
    CCR_SH_NONE = 5'h01,
    CCR_SH_E1   = 5'h02,
    CCR_SH_E2   = 5'h04,
    CCR_SH_E3   = 5'h08,
    CCR_SH_E4   = 5'h10
  } ccr_rate_t;

  // State of the shuffle scheduler.
  typedef struct packed {
    ccr_rate_t  rate;
    logic [1:0] cnt;
    logic       fire;
  } ccr_shuf_t;

  // State of the interrupt collector.
  typedef struct packed {
    logic [3:0] sts;
  } ccr_irq_t;

  // State of the register bank and its bus slave.
  typedef struct packed {
    logic [11:0][7:0] rw;
    logic [3:0]       irq_en;
    logic [2:0]       conv;
    logic [2:0]       link;
    logic             ack;
    logic [7:0]       dat;
  } ccr_top_t;

endpackage

// ===== ccr_shuf_if.sv
// Interface between the register bank and the shuffle scheduler.
`timescale 1ns/10ps
interface ccr_shuf_if;
  logic        en;    // Adaptive shuffling enabled.
  logic [15:0] th;    // Thresholds, every-1 in the low nibble.
  logic [3:0]  data;  // Current ADC sample magnitude.
  logic        fire;  // One-cycle shuffle trigger.
  modport eng (input en, input th, input data, output fire);
  modport ctl (output en, output th, output data, input fire);
endinterface

// ===== ccr_shuffle.sv
// Shuffle scheduler: picks a shuffle rate from the sample and counts it.
`timescale 1ns/10ps
module ccr_shuffle (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  ccr_shuf_if.eng   sif
);

  ccr_pkg::ccr_shuf_t s_q;  // Registered state.
  ccr_pkg::ccr_shuf_t s_d;  // Next state.
  ccr_pkg::ccr_rate_t nr;   // Rate asked for by this sample.
  logic [1:0]         lim;  // Count at which the rate fires.
  logic [1:0]         c;    // Count, restarted on a rate change.

  // The fastest rate whose threshold is met wins.
  always_comb begin
    s_d = s_q;
    nr = ccr_pkg::CCR_SH_NONE;
    lim = 2'h0;
    if (!sif.en) begin
      nr = ccr_pkg::CCR_SH_NONE;
    end else if (sif.data >= sif.th[3:0]) begin
      nr = ccr_pkg::CCR_SH_E1;
    end else if (sif.data >= sif.th[7:4]) begin
      nr = ccr_pkg::CCR_SH_E2;
    end else if (sif.data >= sif.th[11:8]) begin
      nr = ccr_pkg::CCR_SH_E3;
    end else if (sif.data >= sif.th[15:12]) begin
      nr = ccr_pkg::CCR_SH_E4;
    end
    case (nr)
      ccr_pkg::CCR_SH_E1: lim = 2'h0;
      ccr_pkg::CCR_SH_E2: lim = 2'h1;
      ccr_pkg::CCR_SH_E3: lim = 2'h2;
      ccr_pkg::CCR_SH_E4: lim = 2'h3;
      default:            lim = 2'h0;
    endcase
    // A new rate starts its period afresh so it never fires early.
    c = (nr == s_q.rate) ? s_q.cnt : 2'h0;
    s_d.fire = (nr != ccr_pkg::CCR_SH_NONE) && (c == lim);
    s_d.cnt = s_d.fire ? 2'h0 : 2'(c + 2'h1);
    s_d.rate = nr;
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{rate: ccr_pkg::CCR_SH_NONE, cnt: 2'h0, fire: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.fire = s_q.fire;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_every1_fire: assert property (
    (sif.en && sif.data >= sif.th[3:0]) |=> sif.fire)
    else $error("every-1 shuffle did not fire");
  a_off_quiet: assert property (
    !sif.en |=> !sif.fire)
    else $error("shuffle fired while disabled");
  c_every1: cover property (sif.fire [*3]);
endmodule

// ===== ccr_irq.sv
// Interrupt collector: sticky event bits, enables and one level output.
`timescale 1ns/10ps
`include "ccr_params.svh"
module ccr_irq (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] evt_i,   // One-cycle event pulses.
  input  wire logic [3:0] clr_i,   // One-cycle clear pulses.
  input  wire logic [3:0] en_i,    // Interrupt enables.
  output logic      [3:0] sts_o,   // Sticky status.
  output logic            irq_o    // Level interrupt.
);

  ccr_pkg::ccr_irq_t i_q;  // Registered state.
  ccr_pkg::ccr_irq_t i_d;  // Next state.
  logic [3:0]        nxt;  // Per-bit next value.

  // A set in the clearing cycle wins, so no event is lost.
  for (genvar g = 0; g < `CCR_NEVT; g++) begin : g_bit
    assign nxt[g] = evt_i[g] | (i_q.sts[g] & ~clr_i[g]);
  end

  // Copy of the next state.
  always_comb begin
    i_d = i_q;
    i_d.sts = nxt;
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i_q <= '{sts: 4'h0};
    end else begin
      i_q <= i_d;
    end
  end

  assign sts_o = i_q.sts;
  assign irq_o = |(i_q.sts & en_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_set_wins: assert property (
    ((evt_i & clr_i) != 4'h0) |=>
      ((sts_o & $past(evt_i & clr_i)) == $past(evt_i & clr_i)))
    else $error("event lost against clear");
  c_irq_up: cover property ($rose(irq_o));
endmodule

// ===== ccr_clock_synth_regs.sv
// Clock synthesizer and shuffle control register bank on classic Wishbone.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ccr_params.svh"
module ccr_clock_synth_regs (
  input  wire logic        CLK_SYS_I,        // 20 MHz system clock.
  input  wire logic        RST_N_I,          // Asynchronous reset.
  input  wire logic        WB_CYC_I,         // Bus cycle.
  input  wire logic        WB_STB_I,         // Bus strobe.
  input  wire logic        WB_WE_I,          // Write when high.
  input  wire logic [3:0]  WB_SEL_I,         // Byte lanes.
  input  wire logic [11:0] WB_ADR_I,         // Byte address.
  input  wire logic [31:0] WB_DAT_I,         // Write data.
  output logic      [31:0] WB_DAT_O,         // Read data.
  output logic             WB_ACK_O,         // Answer.
  input  wire logic        CONV_LOCK_I,      // Converter synth locked.
  input  wire logic        CONV_CAL_BUSY_I,  // Its oscillator cal busy.
  input  wire logic        CONV_PUMP_DONE_I, // Its pump cal done.
  input  wire logic        LINK_LOCK_I,      // Link synth locked.
  input  wire logic        LINK_CAL_BUSY_I,  // Its oscillator cal busy.
  input  wire logic        LINK_PUMP_DONE_I, // Its pump cal done.
  input  wire logic [3:0]  ADC_DATA_I,       // Sample magnitude.
  output logic             SHUFFLE_O,        // Shuffle trigger pulse.
  output logic [7:0]       STBY_SETTING_O,   // Standby recovery setting.
  output logic [7:0]       SYNTH_EN_O,       // Synth block enables.
  output logic [10:0]      DIV_N_O,          // Integer-N divider.
  output logic             CAL_RESET_O,      // Oscillator cal reset.
  output logic [7:0]       OSC_BIAS_O,       // Oscillator bias.
  output logic [7:0]       OSC_CAL_O,        // Oscillator cal control.
  output logic [5:0]       PUMP_CODE_O,      // Pump current code.
  output logic [1:0]       PUMP_CAL_EN_O,    // Pump cal enable.
  output logic [3:0]       OSC_VAR_O,        // Varactor setting.
  output logic [3:0]       REF_SEL_O,        // Div1, div2, div4, mul2.
  output logic             SYNC_CLK_SEL_O,   // Sync sampling clock.
  output logic             CLKIN_HIGHZ_O,    // Clock input high-Z.
  output logic             IRQ_O             // Level interrupt.
);

  // Slot order of the writable register array.
  localparam logic [11:0][7:0] RW_RST = {
    `CCR_RST_SHUF, `CCR_RST_RDIV, `CCR_RST_VAR, `CCR_RST_PCAL,
    `CCR_RST_PUMP, `CCR_RST_VCO_CAL, `CCR_RST_BIAS, `CCR_RST_CAL_RST,
    `CCR_RST_NHI, `CCR_RST_NLO, `CCR_RST_SYN_EN, `CCR_RST_STBY};

  ccr_pkg::ccr_top_t t_q;      // Registered state.
  ccr_pkg::ccr_top_t t_d;      // Next state.
  logic              rst_m_q;  // Reset release, first stage.
  logic              rst_n;    // Reset release, second stage.
  logic              req;      // Bus request present.
  logic              wr;       // Write commits this edge.
  logic [9:0]        ix;       // Register index.
  logic [4:0]        sl;       // Hit flag and array slot.
  logic [7:0]        rd;       // Byte to be read.
  logic [3:0]        evt;      // Status events.
  logic [3:0]        clr;      // Clear pulses.
  logic [3:0]        sts;      // Sticky status.
  ccr_shuf_if        sif ();   // Shuffle scheduler link.

  // Maps an index to {hit, slot}; used by both read and write paths.
  function automatic logic [4:0] slot_of(input logic [9:0] a);
    if (a == `CCR_IX_STBY) begin
      slot_of = 5'h10;
    end else if (a == `CCR_IX_SYN_EN) begin
      slot_of = 5'h11;
    end else if (a == `CCR_IX_NLO) begin
      slot_of = 5'h12;
    end else if (a == `CCR_IX_NHI) begin
      slot_of = 5'h13;
    end else if (a == `CCR_IX_CAL_RST) begin
      slot_of = 5'h14;
    end else if (a == `CCR_IX_BIAS) begin
      slot_of = 5'h15;
    end else if (a == `CCR_IX_VCO_CAL) begin
      slot_of = 5'h16;
    end else if (a == `CCR_IX_PUMP) begin
      slot_of = 5'h17;
    end else if (a == `CCR_IX_PCAL) begin
      slot_of = 5'h18;
    end else if (a == `CCR_IX_VAR) begin
      slot_of = 5'h19;
    end else if (a == `CCR_IX_RDIV) begin
      slot_of = 5'h1a;
    end else if (a == `CCR_IX_SHUF) begin
      slot_of = 5'h1b;
    end else begin
      slot_of = 5'h00;
    end
  endfunction

  // Turns the two-bit reference code into a one-hot mode.
  function automatic logic [3:0] ref_mode(input logic [1:0] c);
    case (c)
      2'h0:    ref_mode = 4'h1;  // Divide by one.
      2'h1:    ref_mode = 4'h2;  // Divide by two.
      2'h2:    ref_mode = 4'h4;  // Divide by four.
      default: ref_mode = 4'h8;  // Reference doubled.
    endcase
  endfunction

  // The reset is released through two flops to avoid a ragged release.
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  // Request decode; a write lands at the edge the master sees ack.
  assign req = WB_CYC_I & WB_STB_I;
  assign ix  = WB_ADR_I[11:2];
  assign sl  = slot_of(ix);
  assign wr  = req & WB_WE_I & t_q.ack & WB_SEL_I[0];

  // Read multiplexer; nothing here changes state on a read.
  always_comb begin
    rd = 8'h00;
    if (sl[4]) begin
      rd = t_q.rw[sl[3:0]];
    end else if (ix == `CCR_IX_CONV_ST) begin
      rd = {`CCR_ST_TOP, t_q.conv[2], 1'b0, t_q.conv[1:0]};
    end else if (ix == `CCR_IX_LINK_ST) begin
      rd = {`CCR_ST_TOP, t_q.link[2], 1'b0, t_q.link[1:0]};
    end else if (ix == `CCR_IX_TH_LO) begin
      rd = `CCR_TH_LO_RST;
    end else if (ix == `CCR_IX_TH_HI) begin
      rd = `CCR_TH_HI_RST;
    end else if (ix == `CCR_IX_IRQ_EN) begin
      rd = {4'h0, t_q.irq_en};
    end else if (ix == `CCR_IX_IRQ_STS) begin
      rd = {4'h0, sts};
    end
  end

  // Events: lock lost on either synth, converter calibrations done.
  assign evt = {CONV_PUMP_DONE_I & ~t_q.conv[0],
                ~CONV_CAL_BUSY_I & t_q.conv[1],
                ~LINK_LOCK_I & t_q.link[2],
                ~CONV_LOCK_I & t_q.conv[2]};
  assign clr = (wr && ix == `CCR_IX_IRQ_CLR) ? WB_DAT_I[3:0] : 4'h0;

  // Next state of the bank; only the writable slots and the interrupt enables take write data.
  always_comb begin
    t_d = t_q;
    t_d.ack = req & ~t_q.ack;
    t_d.conv = {CONV_LOCK_I, CONV_CAL_BUSY_I, CONV_PUMP_DONE_I};
    t_d.link = {LINK_LOCK_I, LINK_CAL_BUSY_I, LINK_PUMP_DONE_I};
    if (t_d.ack) begin
      t_d.dat = rd;
    end
    if (wr && sl[4]) begin
      t_d.rw[sl[3:0]] = WB_DAT_I[7:0];
    end else if (wr && ix == `CCR_IX_IRQ_EN) begin
      t_d.irq_en = WB_DAT_I[3:0];
    end
  end

  // State register; the shuffle enable comes out of reset set.
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= '{rw: RW_RST, irq_en: 4'h0, conv: 3'h0, link: 3'h0,
               ack: 1'b0, dat: 8'h00};
    end else begin
      t_q <= t_d;
    end
  end

  // Interrupt collector.
  ccr_irq u_irq (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .evt_i   (evt),
    .clr_i   (clr),
    .en_i    (t_q.irq_en),
    .sts_o   (sts),
    .irq_o   (IRQ_O)
  );

  // Shuffle scheduler with its constant thresholds.
  assign sif.en   = t_q.rw[11][`CCR_SHUF_EN_BIT];
  assign sif.th   = {`CCR_TH_HI_RST, `CCR_TH_LO_RST};
  assign sif.data = ADC_DATA_I;
  assign SHUFFLE_O = sif.fire;

  ccr_shuffle u_shuf (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .sif     (sif)
  );

  // Bus outputs come straight from flops.
  assign WB_DAT_O = {24'h0, t_q.dat};
  assign WB_ACK_O = t_q.ack;

  // Control outputs; the pump code is trusted to be set by software.
  assign STBY_SETTING_O = t_q.rw[0];
  assign SYNTH_EN_O     = t_q.rw[1];
  assign DIV_N_O        = {t_q.rw[3][2:0], t_q.rw[2]};
  assign CAL_RESET_O    = t_q.rw[4][3];
  assign OSC_BIAS_O     = t_q.rw[5];
  assign OSC_CAL_O      = t_q.rw[6];
  assign PUMP_CODE_O    = t_q.rw[7][5:0];
  assign PUMP_CAL_EN_O  = t_q.rw[8][7:6];
  assign OSC_VAR_O      = t_q.rw[9][7:4];
  assign REF_SEL_O      = ref_mode(
    t_q.rw[10][`CCR_RDIV_HI:`CCR_RDIV_LO]);
  assign SYNC_CLK_SEL_O = t_q.rw[10][`CCR_SYSREF_BIT];
  assign CLKIN_HIGHZ_O  = t_q.rw[10][`CCR_CLKIN_BIT];

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  a_divider_high: assert property (
    (wr && ix == `CCR_IX_NHI) |=>
      DIV_N_O[10:8] == $past(WB_DAT_I[2:0]))
    else $error("divider high bits not taken");
  a_ref_double: assert property (
    (wr && ix == `CCR_IX_RDIV && WB_DAT_I[7:6] == 2'h3) |=>
      REF_SEL_O == 4'h8)
    else $error("reference doubling not selected");
  a_sync_clock: assert property (
    (wr && ix == `CCR_IX_RDIV) |=>
      SYNC_CLK_SEL_O == $past(WB_DAT_I[3]))
    else $error("sync clock select wrong");
  a_clkin_term: assert property (
    (wr && ix == `CCR_IX_RDIV) |=>
      CLKIN_HIGHZ_O == $past(WB_DAT_I[2]))
    else $error("clock input termination wrong");
  a_conv_status: assert property (
    (req && !WB_WE_I && !t_q.ack && ix == `CCR_IX_CONV_ST) |=>
      WB_DAT_O[3:0] == {$past(CONV_LOCK_I, 2), 1'b0,
                        $past(CONV_CAL_BUSY_I, 2),
                        $past(CONV_PUMP_DONE_I, 2)})
    else $error("converter status read wrong");
  a_link_lock: assert property (
    (req && !WB_WE_I && !t_q.ack && ix == `CCR_IX_LINK_ST) |=>
      WB_DAT_O[3] == $past(LINK_LOCK_I, 2))
    else $error("link lock read wrong");
  a_shuffle_default: assert property (
    $rose(rst_n) |-> sif.en)
    else $error("adaptive shuffle off after reset");
  a_threshold_fixed: assert property (
    (req && !WB_WE_I && !t_q.ack && ix == `CCR_IX_TH_LO) |=>
      WB_DAT_O[7:0] == `CCR_TH_LO_RST)
    else $error("threshold register changed");
  c_write: cover property (wr && sl[4]);
  c_irq: cover property (IRQ_O ##1 clr != 4'h0);
endmodule

// ===== ccr_testbench.sv
// Self-checking bench for the clock synth register bank.
`timescale 1ns/10ps
`include "ccr_params.svh"
module testbench;
  logic        clk;       // System clock, 50 ns period.
  logic        rst_n;     // Active-low reset.
  logic        cyc;       // Bus cycle.
  logic        stb;       // Bus strobe.
  logic        we;        // Bus write.
  logic [11:0] adr;       // Byte address.
  logic [31:0] wdat;      // Write data.
  logic [31:0] rdat;      // Read data.
  logic        ack;       // Bus answer.
  logic        c_lock;    // Converter synth locked.
  logic        c_busy;    // Converter oscillator cal busy.
  logic        c_done;    // Converter pump cal done.
  logic        l_lock;    // Link synth locked.
  logic        l_busy;    // Link oscillator cal busy.
  logic        l_done;    // Link pump cal done.
  logic [3:0]  adc;       // Sample magnitude.
  logic        shuf;      // Shuffle trigger.
  logic        irq;       // Level interrupt.
  logic [7:0]  stby;      // Standby recovery setting.
  logic [10:0] div_n;     // Integer-N divider.
  logic [5:0]  pump;      // Pump current code.
  logic [3:0]  ref_sel;   // One-hot reference mode.
  logic        sync_sel;  // Sync sampling clock select.
  logic        clkin_hz;  // Clock input high impedance.
  logic [7:0]  syn_en;    // Synth block enables.
  logic [7:0]  bias;      // Oscillator bias.
  logic [7:0]  oscal;     // Oscillator cal control.
  logic        cal_rst;   // Oscillator cal reset.
  logic [1:0]  pcal;      // Pump cal enable.
  logic [3:0]  var_o;     // Varactor setting.
  int          n_errors;  // Mismatches seen.
  int          check_count; // Comparisons made.
  int          cycles;    // Cycles since time zero.

  // Register index and reset value, for the reset sweep.
  localparam logic [17:0] TBL [16] = '{
    {`CCR_IX_STBY, `CCR_RST_STBY}, {`CCR_IX_SYN_EN, `CCR_RST_SYN_EN},
    {`CCR_IX_NLO, `CCR_RST_NLO}, {`CCR_IX_NHI, `CCR_RST_NHI},
    {`CCR_IX_CAL_RST, `CCR_RST_CAL_RST}, {`CCR_IX_BIAS, `CCR_RST_BIAS},
    {`CCR_IX_VCO_CAL, `CCR_RST_VCO_CAL}, {`CCR_IX_PUMP, `CCR_RST_PUMP},
    {`CCR_IX_PCAL, `CCR_RST_PCAL}, {`CCR_IX_VAR, `CCR_RST_VAR},
    {`CCR_IX_RDIV, `CCR_RST_RDIV}, {`CCR_IX_SHUF, `CCR_RST_SHUF},
    {`CCR_IX_TH_LO, 8'hf5}, {`CCR_IX_TH_HI, 8'hff},
    {`CCR_IX_CONV_ST, 8'h80}, {`CCR_IX_LINK_ST, 8'h80}};

  // Every control output is watched as well as read back.
  ccr_clock_synth_regs DUT (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_SEL_I(4'h1), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .CONV_LOCK_I(c_lock),
    .CONV_CAL_BUSY_I(c_busy), .CONV_PUMP_DONE_I(c_done),
    .LINK_LOCK_I(l_lock), .LINK_CAL_BUSY_I(l_busy),
    .LINK_PUMP_DONE_I(l_done), .ADC_DATA_I(adc), .SHUFFLE_O(shuf),
    .STBY_SETTING_O(stby), .SYNTH_EN_O(syn_en), .DIV_N_O(div_n),
    .CAL_RESET_O(cal_rst), .OSC_BIAS_O(bias), .OSC_CAL_O(oscal),
    .PUMP_CODE_O(pump), .PUMP_CAL_EN_O(pcal), .OSC_VAR_O(var_o),
    .REF_SEL_O(ref_sel),
    .SYNC_CLK_SEL_O(sync_sel), .CLKIN_HIGHZ_O(clkin_hz), .IRQ_O(irq));

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // Compares one value and counts the result.
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One classic cycle. Values read at a rising edge are the ones from
  // before that edge, so ack and data are taken at the same edge.
  task automatic bus(input logic w, input logic [9:0] ix,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat[7:0];
    chk("bus ack", 16'h0001, 16'(ack));
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, ix, d, v);
  endtask

  task automatic rdc(input string what, input logic [9:0] ix,
                     input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, ix, 8'h00, v);
    chk(what, 16'(exp), 16'(v));
  endtask

  // Reset values of every register except the interrupt ones, and of the decoded outputs other than stby and pump.
  task automatic t_reset;
    foreach (TBL[i]) rdc("reset value", TBL[i][17:8], TBL[i][7:0]);
    chk("div_n reset", 16'h0080, 16'(div_n));
    chk("ref_sel reset", 16'h0004, 16'(ref_sel));
    chk("sync_sel reset", 16'h0001, 16'(sync_sel));
    chk("clkin reset", 16'h0000, 16'(clkin_hz));
    chk("syn_en reset", 16'h0000, 16'(syn_en));
    chk("bias reset", 16'h0037, 16'(bias));
    chk("oscal reset", 16'h00c0, 16'(oscal));
    chk("cal_rst reset", 16'h0000, 16'(cal_rst));
    chk("pcal reset", 16'h0000, 16'(pcal));
    chk("var reset", 16'h000d, 16'(var_o));
  endtask

  // Divider spans two registers; reserved bits must not leak into it.
  task automatic t_divider;
    wr(`CCR_IX_NLO, 8'h5a);
    wr(`CCR_IX_NHI, 8'hfd);
    tick(2);
    chk("div_n", 16'h055a, 16'(div_n));
    rdc("nhi readback", `CCR_IX_NHI, 8'hfd);
    wr(10'h251, 8'h3c);
    rdc("unmapped", 10'h251, 8'h00);
  endtask

  // Every reference code, with the two select bits varied alongside.
  task automatic t_refdiv;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(`CCR_IX_RDIV, {c, 2'b11, c[0], c[1], 2'b01});
      tick(2);
      chk("ref_sel", 16'h0001 << i, 16'(ref_sel));
      chk("sync_sel", 16'(c[0]), 16'(sync_sel));
      chk("clkin", 16'(c[1]), 16'(clkin_hz));
    end
  endtask

  // Status bits follow the inputs; writes to read-only places do nothing.
  task automatic t_status;
    @(posedge clk);
    {c_lock, c_busy, c_done} <= 3'b101;
    {l_lock, l_busy, l_done} <= 3'b110;
    tick(3);
    rdc("conv status", `CCR_IX_CONV_ST, 8'h89);
    rdc("link status", `CCR_IX_LINK_ST, 8'h8a);
    @(posedge clk);
    {c_lock, c_busy, c_done} <= 3'b010;
    {l_lock, l_busy, l_done} <= 3'b001;
    tick(3);
    rdc("conv status", `CCR_IX_CONV_ST, 8'h82);
    rdc("link status", `CCR_IX_LINK_ST, 8'h81);
    wr(`CCR_IX_CONV_ST, 8'h00);
    wr(`CCR_IX_TH_LO, 8'h00);
    wr(`CCR_IX_TH_HI, 8'h00);
    rdc("conv status", `CCR_IX_CONV_ST, 8'h82);
    rdc("threshold lo", `CCR_IX_TH_LO, 8'hf5);
    rdc("threshold hi", `CCR_IX_TH_HI, 8'hff);
  endtask

  // Raise, mask and clear events; c_lock and l_lock start low here.
  task automatic t_irq;
    wr(`CCR_IX_IRQ_CLR, 8'h0f);
    wr(`CCR_IX_IRQ_EN, 8'h01);
    rdc("irq status", `CCR_IX_IRQ_STS, 8'h00);
    @(posedge clk);
    c_lock <= 1'b1;
    l_lock <= 1'b1;
    tick(2);
    c_lock <= 1'b0;
    tick(2);
    chk("irq enabled", 16'h0001, 16'(irq));
    rdc("irq status", `CCR_IX_IRQ_STS, 8'h01);
    wr(`CCR_IX_IRQ_CLR, 8'h01);
    tick(2);
    chk("irq cleared", 16'h0000, 16'(irq));
    @(posedge clk);
    l_lock <= 1'b0;
    tick(2);
    chk("irq masked", 16'h0000, 16'(irq));
    rdc("irq status", `CCR_IX_IRQ_STS, 8'h02);
    wr(`CCR_IX_IRQ_EN, 8'h02);
    tick(2);
    chk("irq unmasked", 16'h0001, 16'(irq));
    @(posedge clk);
    c_busy <= 1'b0;
    c_done <= 1'b1;
    tick(2);
    rdc("irq status", `CCR_IX_IRQ_STS, 8'h0e);
    wr(`CCR_IX_IRQ_CLR, 8'h0f);
    rdc("irq status", `CCR_IX_IRQ_STS, 8'h00);
    chk("irq idle", 16'h0000, 16'(irq));
  endtask

  // Holds one sample level and checks the trigger against exp on four cycles in a row.
  task automatic shuf_run(input logic [3:0] d, input logic exp);
    @(posedge clk);
    adc <= d;
    tick(2);
    repeat (4) begin
      @(posedge clk);
      chk("shuffle", 16'(exp), 16'(shuf));
    end
  endtask

  // Threshold boundary, below it, and the enable bit.
  task automatic t_shuffle;
    shuf_run(4'h7, 1'b1);
    shuf_run(4'h5, 1'b1);
    shuf_run(4'h4, 1'b0);
    wr(`CCR_IX_SHUF, 8'h02);
    shuf_run(4'hf, 1'b0);
    wr(`CCR_IX_SHUF, 8'h03);
    shuf_run(4'hf, 1'b1);
    shuf_run(4'h0, 1'b0);
  endtask

  // Largest pump code and the faster standby recovery value.
  task automatic t_misc;
    wr(`CCR_IX_PUMP, 8'h3f);
    wr(`CCR_IX_STBY, 8'h95);
    wr(`CCR_IX_CAL_RST, 8'h08);
    wr(`CCR_IX_PCAL, 8'hc0);
    wr(`CCR_IX_VAR, 8'ha0);
    wr(`CCR_IX_SYN_EN, 8'h24);
    tick(2);
    chk("cal_rst", 16'h0001, 16'(cal_rst));
    chk("pcal", 16'h0003, 16'(pcal));
    chk("var", 16'h000a, 16'(var_o));
    chk("syn_en", 16'h0024, 16'(syn_en));
    chk("pump code", 16'h003f, 16'(pump));
    chk("standby", 16'h0095, 16'(stby));
    rdc("pump readback", `CCR_IX_PUMP, 8'h3f);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    {cyc, stb, we, adr, wdat} = '0;
    {c_lock, c_busy, c_done, l_lock, l_busy, l_done} = '0;
    adc = 4'h0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    rst_n = 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(4);
    t_reset();
    t_divider();
    t_refdiv();
    t_status();
    t_irq();
    t_shuffle();
    t_misc();
    report_and_stop();
  end
endmodule
